// ---- hdl/dual_issue_pipeline_interlock.sv ----
/*
  Issue and interlock control of a dual-issue pipeline: pairing, register
  scoreboard (flow, output and anti-flow), resource locks, issue rate,
  fetch stall and data freeze, plus stage occupancy tracking.
  Assumes the fetch path presents the older instruction in slot 0 and the
  younger in slot 1, already decoded, and shifts slot 1 into slot 0 when
  holdYoung is high. All inputs are synchronous to clock.
*/
// Behaviour
// RULE1 - five stages: fetch, decode, execute, access, writeback
// RULE2 - six groups; pairing decided by group combination
// RULE3 - integer add pairs with unconditional jump
// RULE4 - all counts are core clock cycles
// RULE5 - issue spacing follows earlier issue rate
// RULE6 - no shared stages except paired issue
// RULE7 - read-after-write stalls for producer latency
// RULE8 - write-after-write: latency minus one or two
// RULE9 - write-after-read: five after vector, two after double
// RULE10 - float result to float store: one less
// RULE11 - load feeding shift count: one more
// RULE12 - short latency into double/vector raised to two
// RULE13 - output dependency: float then load-store, same dest
// RULE14 - output stall uses longest writeback latency
// RULE15 - status register updates never stall
// RULE16 - write-after-read only for listed instruction pairs
// RULE17 - locked resource stalls users until released
// RULE18 - load then dependent add stalls two cycles
// RULE19 - stall on fetch misses and external accesses
// RULE20 - fetch penalty: no issue, pipeline keeps advancing
// RULE21 - data access penalty freezes whole pipeline
// RULE22 - divide and root occupy iterative stage
// RULE23 - compare pair against pending writes each cycle
// RULE24 - older issues alone, younger held in order
`timescale 1ns/1ps
`default_nettype none

module dual_issue_pipeline_interlock (
  input  wire logic                        clock, // RULE4
  input  wire logic                        rst,
  input  wire logic [1:0]                  slotValid,
  input  wire pipe_pkg::group_t            slotGroup      [0:1],
  input  wire pipe_pkg::kind_t             slotKind       [0:1],
  input  wire logic [pipe_pkg::REG_W-1:0]  slotSrcA       [0:1],
  input  wire logic [pipe_pkg::REG_W-1:0]  slotSrcB       [0:1],
  input  wire logic [pipe_pkg::REG_W-1:0]  slotDst        [0:1],
  input  wire logic [1:0]                  slotSrcAUse,
  input  wire logic [1:0]                  slotSrcBUse,
  input  wire logic [1:0]                  slotDstUse,
  input  wire logic [pipe_pkg::LAT_W-1:0]  slotLatency    [0:1],
  input  wire logic [pipe_pkg::LAT_W-1:0]  slotWbLatency  [0:1],
  input  wire logic [pipe_pkg::RATE_W-1:0] slotIssueRate  [0:1],
  input  wire logic [pipe_pkg::NUM_RES-1:0] slotLockMask  [0:1],
  input  wire logic [pipe_pkg::LSTART_W-1:0] slotLockStart [0:1],
  input  wire logic [pipe_pkg::LAT_W-1:0]  slotLockCycles [0:1],
  input  wire logic [pipe_pkg::NUM_RES-1:0] slotNeedMask  [0:1],
  input  wire logic                        itlbMiss,
  input  wire logic                        extInstrFetch,
  input  wire logic                        extDataWait,
  input  wire logic                        ctrlRegWait,
  output logic                             issueOld,
  output logic                             issueYoung,
  output logic                             holdYoung,
  output logic                             fetchStall,
  output logic                             pipeFrozen,
  output logic [1:0]                       execValid,
  output logic [1:0]                       accessValid,
  output logic [1:0]                       accessIsMemory,
  output logic [1:0]                       writebackValid,
  output logic                             iterBusy
);

  localparam int LW = pipe_pkg::LAT_W;
  localparam int NR = pipe_pkg::NUM_RES;

  // scoreboard: one entry per register, tracks the last writer and reader
  logic [LW-1:0]  lat_r     [pipe_pkg::NUM_REGS];
  logic [LW-1:0]  wbLat_r   [pipe_pkg::NUM_REGS];
  logic [LW-1:0]  age_r     [pipe_pkg::NUM_REGS];
  pipe_pkg::kind_t prodKind_r [pipe_pkg::NUM_REGS];
  logic           prodFloat_r [pipe_pkg::NUM_REGS];
  logic [LW-1:0]  warLimit_r [pipe_pkg::NUM_REGS];
  logic [LW-1:0]  warAge_r  [pipe_pkg::NUM_REGS];

  logic [pipe_pkg::LSTART_W-1:0] lockDelay_r [NR];
  logic [LW-1:0]  lockCnt_r [NR];
  logic [pipe_pkg::RATE_W-1:0] rateCnt_r;
  logic [1:0]     execValid_r;
  logic [1:0]     execMem_r;
  logic [1:0]     accessValid_r;
  logic [1:0]     accessMem_r;
  logic [1:0]     writebackValid_r;

  logic [NR-1:0]  locked;
  logic [1:0]     hazard;
  logic [1:0]     issued;
  logic [1:0]     slotMem;
  logic [NR-1:0]  effLockMask [0:1];
  logic [LW-1:0]  effLockCycles [0:1];
  logic           canIssue;
  logic           pairOk;
  logic           intraDep;

  function automatic logic isFpCompute(input pipe_pkg::kind_t k);
    return k inside {pipe_pkg::KIND_FP_COMPUTE, pipe_pkg::KIND_FP_QUOTIENT_ROOT,
                     pipe_pkg::KIND_FP_DOUBLE_SDP, pipe_pkg::KIND_FP_DOUBLE_OTHER,
                     pipe_pkg::KIND_FP_INNER, pipe_pkg::KIND_FP_VECTOR};
  endfunction

  function automatic logic isWideFp(input pipe_pkg::kind_t k);
    return k inside {pipe_pkg::KIND_FP_DOUBLE_SDP, pipe_pkg::KIND_FP_DOUBLE_OTHER,
                     pipe_pkg::KIND_FP_INNER, pipe_pkg::KIND_FP_VECTOR};
  endfunction

  function automatic logic isWarReader(input pipe_pkg::kind_t k);
    return k inside {pipe_pkg::KIND_FP_WAR_READER, pipe_pkg::KIND_FP_STORE};
  endfunction

  // group pairing table; serial-only never pairs, alike groups do not share
  // a function block except register moves
  function automatic logic canPair(input pipe_pkg::group_t a, input pipe_pkg::group_t b);
    if (a == pipe_pkg::SERIAL_ONLY_GROUP || b == pipe_pkg::SERIAL_ONLY_GROUP) begin // RULE2
      return 1'b0;
    end
    if (a == b) begin
      return a == pipe_pkg::MOVE_TRANSFER_GROUP;
    end
    return 1'b1; // RULE3
  endfunction

  // effective flow latency of a stored producer as seen by one consumer
  function automatic logic [LW-1:0] flowLat(input logic [LW-1:0] lat,
                                            input pipe_pkg::kind_t prod,
                                            input pipe_pkg::kind_t cons,
                                            input logic shiftCount);
    logic [LW-1:0] l;
    l = lat;
    if (isFpCompute(prod) && cons == pipe_pkg::KIND_FP_STORE && l != '0) begin
      l = l - pipe_pkg::FP_STORE_TRIM; // RULE10
    end
    if (prod == pipe_pkg::KIND_LOAD && cons == pipe_pkg::KIND_DYN_SHIFT && shiftCount &&
        l != pipe_pkg::AGE_MAX) begin
      l = l + pipe_pkg::SHIFT_LOAD_ADD; // RULE11
    end
    if (isWideFp(cons) && l < pipe_pkg::DOUBLE_MIN_LAT) begin
      l = pipe_pkg::DOUBLE_MIN_LAT; // RULE12
    end
    return l;
  endfunction

  assign pipeFrozen = extDataWait | ctrlRegWait; // RULE19 RULE21
  assign fetchStall = itlbMiss | extInstrFetch; // RULE19 RULE20

  genvar gr;
  generate
    for (gr = 0; gr < NR; gr++) begin : g_lock
      assign locked[gr] = (lockCnt_r[gr] != '0) && (lockDelay_r[gr] == pipe_pkg::LSTART_ZERO);
    end
  endgenerate

  assign iterBusy = (lockCnt_r[pipe_pkg::RES_ITER] != '0); // RULE22

  // per-slot hazard against in-flight writes and readers
  always_comb begin // RULE23
    pipe_pkg::kind_t k;
    logic [LW-1:0] trim;
    k    = pipe_pkg::KIND_PLAIN;
    trim = '0;
    for (int s = 0; s < 2; s++) begin
      k = slotKind[s];
      hazard[s] = 1'b0;
      if (slotSrcAUse[s] &&
          age_r[slotSrcA[s]] < flowLat(lat_r[slotSrcA[s]], prodKind_r[slotSrcA[s]], k, 1'b0)) begin
        hazard[s] = 1'b1; // RULE7 RULE18
      end
      if (slotSrcBUse[s] &&
          age_r[slotSrcB[s]] < flowLat(lat_r[slotSrcB[s]], prodKind_r[slotSrcB[s]], k, 1'b1)) begin
        hazard[s] = 1'b1; // RULE7 RULE11
      end
      trim = (prodKind_r[slotDst[s]] == pipe_pkg::KIND_FP_QUOTIENT_ROOT) ?
             pipe_pkg::WAW_TRIM_ITER : pipe_pkg::WAW_TRIM_FLOAT; // RULE8
      if (slotDstUse[s] && slotGroup[s] == pipe_pkg::LOAD_STORE_GROUP &&
          prodFloat_r[slotDst[s]] && wbLat_r[slotDst[s]] > trim &&
          age_r[slotDst[s]] < wbLat_r[slotDst[s]] - trim) begin
        hazard[s] = 1'b1; // RULE13 RULE14
      end
      if (slotDstUse[s] && isWarReader(k) &&
          warAge_r[slotDst[s]] < warLimit_r[slotDst[s]]) begin
        hazard[s] = 1'b1; // RULE9 RULE16
      end
      if ((slotNeedMask[s] & locked) != '0) begin
        hazard[s] = 1'b1; // RULE17
      end
    end
  end

  // younger depends on older of the same pair; status register is not tracked
  assign intraDep = slotDstUse[0] &&
                    ((slotSrcAUse[1] && slotSrcA[1] == slotDst[0]) ||
                     (slotSrcBUse[1] && slotSrcB[1] == slotDst[0]) ||
                     (slotDstUse[1] && slotDst[1] == slotDst[0])); // RULE15 RULE23
  assign pairOk   = canPair(slotGroup[0], slotGroup[1]) && !intraDep &&
                    slotIssueRate[0] <= pipe_pkg::RATE_ONE &&
                    (slotNeedMask[1] & effLockMask[0]) == '0; // RULE2 RULE6

  assign canIssue   = !pipeFrozen && !fetchStall && rateCnt_r == '0; // RULE5 RULE20 RULE21
  assign issueOld   = canIssue && slotValid[0] && !hazard[0];
  assign issueYoung = issueOld && slotValid[1] && !hazard[1] && pairOk; // RULE24
  assign holdYoung  = slotValid[1] && issueOld && !issueYoung; // RULE24
  assign issued     = {issueYoung, issueOld};

  generate
    for (gr = 0; gr < 2; gr++) begin : g_slot
      assign slotMem[gr] = slotGroup[gr] == pipe_pkg::LOAD_STORE_GROUP;
      assign effLockMask[gr] = slotLockMask[gr] |
             ((slotKind[gr] == pipe_pkg::KIND_FP_QUOTIENT_ROOT) ?
              NR'(1 << pipe_pkg::RES_ITER) : '0); // RULE22
      assign effLockCycles[gr] = (slotKind[gr] == pipe_pkg::KIND_FP_QUOTIENT_ROOT &&
                                  slotLockCycles[gr] == '0) ?
                                 slotLatency[gr] : slotLockCycles[gr];
    end
  endgenerate

  // stage occupancy; bubbles enter on no issue, everything holds on freeze
  always_ff @(posedge clock or posedge rst) begin // RULE1 RULE6
    if (rst) begin
      execValid_r      <= 2'h0;
      execMem_r        <= 2'h0;
      accessValid_r    <= 2'h0;
      accessMem_r      <= 2'h0;
      writebackValid_r <= 2'h0;
    end else if (!pipeFrozen) begin // RULE21
      execValid_r      <= issued;
      execMem_r        <= issued & slotMem;
      accessValid_r    <= execValid_r;
      accessMem_r      <= execMem_r;
      writebackValid_r <= accessValid_r;
    end
  end

  assign execValid      = execValid_r;
  assign accessValid    = accessValid_r;
  assign accessIsMemory = accessMem_r;
  assign writebackValid = writebackValid_r;

  // issue spacing from the last instruction issued
  always_ff @(posedge clock or posedge rst) begin // RULE5
    if (rst) begin
      rateCnt_r <= 4'h0;
    end else if (!pipeFrozen) begin
      if (issueYoung && slotIssueRate[1] != '0) begin
        rateCnt_r <= slotIssueRate[1] - pipe_pkg::RATE_ONE;
      end else if (issueOld && !issueYoung && slotIssueRate[0] != '0) begin
        rateCnt_r <= slotIssueRate[0] - pipe_pkg::RATE_ONE;
      end else if (rateCnt_r != '0) begin
        rateCnt_r <= rateCnt_r - pipe_pkg::RATE_ONE;
      end
    end
  end

  // resource locks; younger issue overrides older on the same resource
  always_ff @(posedge clock or posedge rst) begin // RULE17
    if (rst) begin
      for (int r = 0; r < NR; r++) begin
        lockDelay_r[r] <= 3'h0;
        lockCnt_r[r]   <= 5'h00;
      end
    end else if (!pipeFrozen) begin
      for (int r = 0; r < NR; r++) begin
        if (lockDelay_r[r] != '0) begin
          lockDelay_r[r] <= lockDelay_r[r] - 3'h1;
        end else if (lockCnt_r[r] != '0) begin
          lockCnt_r[r] <= lockCnt_r[r] - pipe_pkg::LAT_ONE;
        end
        for (int s = 0; s < 2; s++) begin
          if (issued[s] && effLockMask[s][r]) begin
            lockDelay_r[r] <= slotLockStart[s];
            lockCnt_r[r]   <= effLockCycles[s];
          end
        end
      end
    end
  end

  // scoreboard ages advance every unfrozen cycle; issue restarts an entry
  always_ff @(posedge clock or posedge rst) begin // RULE23
    if (rst) begin
      for (int i = 0; i < pipe_pkg::NUM_REGS; i++) begin
        lat_r[i]       <= 5'h00;
        wbLat_r[i]     <= 5'h00;
        age_r[i]       <= 5'h1F;
        prodKind_r[i]  <= pipe_pkg::KIND_PLAIN;
        prodFloat_r[i] <= 1'b0;
        warLimit_r[i]  <= 5'h00;
        warAge_r[i]    <= 5'h1F;
      end
    end else if (!pipeFrozen) begin // RULE21
      for (int i = 0; i < pipe_pkg::NUM_REGS; i++) begin
        if (age_r[i] != pipe_pkg::AGE_MAX) begin
          age_r[i] <= age_r[i] + pipe_pkg::LAT_ONE;
        end
        if (warAge_r[i] != pipe_pkg::AGE_MAX) begin
          warAge_r[i] <= warAge_r[i] + pipe_pkg::LAT_ONE;
        end
      end
      for (int s = 0; s < 2; s++) begin
        if (issued[s] && slotDstUse[s]) begin
          lat_r[slotDst[s]]       <= slotLatency[s]; // RULE7
          wbLat_r[slotDst[s]]     <= slotWbLatency[s]; // RULE14
          age_r[slotDst[s]]       <= 5'h00;
          prodKind_r[slotDst[s]]  <= slotKind[s];
          prodFloat_r[slotDst[s]] <= slotGroup[s] == pipe_pkg::FLOAT_UNIT_GROUP; // RULE13
        end
        if (issued[s] && (slotKind[s] == pipe_pkg::KIND_FP_VECTOR ||
                          slotKind[s] == pipe_pkg::KIND_FP_DOUBLE_SDP)) begin
          if (slotSrcAUse[s]) begin
            warLimit_r[slotSrcA[s]] <= (slotKind[s] == pipe_pkg::KIND_FP_VECTOR) ?
                                       pipe_pkg::WAR_LAT_VECTOR : pipe_pkg::WAR_LAT_DOUBLE; // RULE9
            warAge_r[slotSrcA[s]]   <= 5'h00;
          end
          if (slotSrcBUse[s]) begin
            warLimit_r[slotSrcB[s]] <= (slotKind[s] == pipe_pkg::KIND_FP_VECTOR) ?
                                       pipe_pkg::WAR_LAT_VECTOR : pipe_pkg::WAR_LAT_DOUBLE; // RULE9
            warAge_r[slotSrcB[s]]   <= 5'h00;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- pkg/pipe_pkg.sv ----
/*
  Shared constants and types for the dual-issue issue and interlock control:
  instruction groups, decoded instruction kinds, scoreboard sizes and the
  stall figures of the dependency checks.
  Assumes the decode path classifies every instruction into group_t and kind_t.
*/
`default_nettype none

package pipe_pkg;

  localparam int REG_W   = 6;
  localparam int NUM_REGS = 64;
  localparam int LAT_W   = 5;
  localparam int RATE_W  = 4;
  localparam int LSTART_W = 3;
  localparam int NUM_RES = 4;
  localparam int NUM_SLOTS = 2;
  localparam int NUM_GROUPS = 6;
  localparam int NUM_BASIC_STAGES = 5;

  // resource index of the iterative divide / root stage
  localparam int RES_ITER = 3;

  localparam logic [LAT_W-1:0] AGE_MAX        = 5'h1F;
  localparam logic [LAT_W-1:0] WAR_LAT_VECTOR = 5'h05;
  localparam logic [LAT_W-1:0] WAR_LAT_DOUBLE = 5'h02;
  localparam logic [LAT_W-1:0] WAW_TRIM_ITER  = 5'h01;
  localparam logic [LAT_W-1:0] WAW_TRIM_FLOAT = 5'h02;
  localparam logic [LAT_W-1:0] FP_STORE_TRIM  = 5'h01;
  localparam logic [LAT_W-1:0] SHIFT_LOAD_ADD = 5'h01;
  localparam logic [LAT_W-1:0] DOUBLE_MIN_LAT = 5'h02;
  localparam logic [LAT_W-1:0] LAT_ONE        = 5'h01;
  localparam logic [RATE_W-1:0] RATE_ONE      = 4'h1;
  localparam logic [LSTART_W-1:0] LSTART_ZERO = 3'h0;

  typedef enum logic [2:0] {
    MOVE_TRANSFER_GROUP,
    ARITH_LOGIC_GROUP,
    JUMP_GROUP,
    LOAD_STORE_GROUP,
    FLOAT_UNIT_GROUP,
    SERIAL_ONLY_GROUP
  } group_t;

  typedef enum logic [3:0] {
    KIND_PLAIN,
    KIND_LOAD,
    KIND_ADD,
    KIND_DYN_SHIFT,
    KIND_UNCOND_JUMP,
    KIND_FP_COMPUTE,
    KIND_FP_STORE,
    KIND_FP_QUOTIENT_ROOT,
    KIND_FP_DOUBLE_SDP,
    KIND_FP_DOUBLE_OTHER,
    KIND_FP_INNER,
    KIND_FP_VECTOR,
    KIND_FP_WAR_READER
  } kind_t;

endpackage

`default_nettype wire

// ---- verification/dual_issue_pipeline_interlock_bench.sv ----
/*
  Bench for the dual-issue interlock: stall figures from a table of
  producer/consumer pairs, then pairing, fetch stall and data freeze.
  Assumes pipe_pkg, the interlock, its monitor and fetch_feed_model.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_issue_pipeline_interlock_bench;
  typedef struct {
    pipe_pkg::kind_t k;
    logic [5:0]      a, b, d;
    logic [4:0]      lat, wb;
    logic [3:0]      rate, lock, need;
  } insn_t;
  typedef struct {insn_t p; insn_t c; int n;} row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [1:0] offerBits = 2'h0;
  logic offerTog = 1'b0;
  logic itlbMiss = 1'b0;
  logic extInstrFetch = 1'b0;
  logic extDataWait = 1'b0;
  logic ctrlRegWait = 1'b0;
  logic [1:0] aUse = 2'h3;
  pipe_pkg::group_t slotGroup [0:1];
  pipe_pkg::kind_t slotKind [0:1];
  logic [5:0] slotSrcA [0:1], slotSrcB [0:1], slotDst [0:1];
  logic [4:0] slotLatency [0:1], slotWbLatency [0:1], slotLockCycles [0:1];
  logic [3:0] slotIssueRate [0:1], slotLockMask [0:1], slotNeedMask [0:1];
  logic [2:0] slotLockStart [0:1] = '{3'h0, 3'h0};
  logic [1:0] slotValid, execValid, accessValid, accessIsMemory, writebackValid;
  logic issueOld, issueYoung, holdYoung, fetchStall, pipeFrozen, iterBusy;
  int nErrors = 0;
  int samplesChecked = 0;
  int n;
  // fields: kind, srcA, srcB, dst, latency, wb latency, rate, lock, need
  row_t rows [12] = '{
    '{'{pipe_pkg::KIND_LOAD,0,0,1,2,2,1,0,0},
      '{pipe_pkg::KIND_ADD,1,0,20,1,1,1,0,0},2},
    '{'{pipe_pkg::KIND_LOAD,0,0,1,2,2,1,0,0},
      '{pipe_pkg::KIND_DYN_SHIFT,0,1,20,1,1,1,0,0},3},
    '{'{pipe_pkg::KIND_FP_COMPUTE,0,0,2,4,4,1,0,0},
      '{pipe_pkg::KIND_FP_STORE,2,0,40,1,1,1,0,0},3},
    '{'{pipe_pkg::KIND_PLAIN,0,0,3,1,1,1,0,0},
      '{pipe_pkg::KIND_FP_INNER,3,0,20,1,1,1,0,0},2},
    '{'{pipe_pkg::KIND_FP_QUOTIENT_ROOT,0,0,8,10,10,1,0,0},
      '{pipe_pkg::KIND_LOAD,0,0,8,1,1,1,0,0},9},
    '{'{pipe_pkg::KIND_FP_COMPUTE,0,0,9,3,6,1,0,0},
      '{pipe_pkg::KIND_LOAD,0,0,9,1,1,1,0,0},4},
    '{'{pipe_pkg::KIND_FP_VECTOR,10,0,11,7,7,1,0,0},
      '{pipe_pkg::KIND_FP_WAR_READER,0,0,10,1,1,1,0,0},5},
    '{'{pipe_pkg::KIND_FP_DOUBLE_SDP,13,0,12,4,4,1,0,0},
      '{pipe_pkg::KIND_FP_WAR_READER,0,0,13,1,1,1,0,0},2},
    '{'{pipe_pkg::KIND_FP_VECTOR,14,0,11,7,7,1,0,0},
      '{pipe_pkg::KIND_ADD,0,0,14,1,1,1,0,0},0},
    '{'{pipe_pkg::KIND_FP_QUOTIENT_ROOT,0,0,15,10,10,1,0,0},
      '{pipe_pkg::KIND_FP_COMPUTE,0,0,16,1,1,1,0,0},0},
    '{'{pipe_pkg::KIND_PLAIN,0,0,17,1,1,3,0,0},
      '{pipe_pkg::KIND_PLAIN,0,0,18,1,1,1,0,0},2},
    '{'{pipe_pkg::KIND_PLAIN,0,0,19,3,3,1,1,0},
      '{pipe_pkg::KIND_PLAIN,0,0,21,1,1,1,0,1},3}};

  dual_issue_pipeline_interlock u_dut (
    .clock, .rst, .slotValid, .slotGroup, .slotKind, .slotSrcA, .slotSrcB, .slotDst,
    .slotSrcAUse(aUse), .slotSrcBUse(2'h3), .slotDstUse(2'h3), .slotLatency,
    .slotWbLatency, .slotIssueRate, .slotLockMask, .slotLockStart, .slotLockCycles,
    .slotNeedMask, .itlbMiss, .extInstrFetch, .extDataWait, .ctrlRegWait, .issueOld,
    .issueYoung, .holdYoung, .fetchStall, .pipeFrozen, .execValid, .accessValid,
    .accessIsMemory, .writebackValid, .iterBusy);
  fetch_feed_model u_feed (.clock, .rst, .offer(offerBits), .offerTog, .issueOld,
    .issueYoung, .slotValid);

  always #2 clock = ~clock;

  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic chkBit(input string what, input logic exp, input logic got);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkInt(input string what, input int exp, input int got);
    samplesChecked++;
    if (got != exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic pipe_pkg::group_t grp(input pipe_pkg::kind_t k);
    case (k)
      pipe_pkg::KIND_PLAIN: return pipe_pkg::MOVE_TRANSFER_GROUP;
      pipe_pkg::KIND_ADD, pipe_pkg::KIND_DYN_SHIFT: return pipe_pkg::ARITH_LOGIC_GROUP;
      pipe_pkg::KIND_LOAD, pipe_pkg::KIND_FP_STORE,
      pipe_pkg::KIND_FP_WAR_READER: return pipe_pkg::LOAD_STORE_GROUP;
      default: return pipe_pkg::FLOAT_UNIT_GROUP;
    endcase
  endfunction
  task automatic setSlot(input int i, input pipe_pkg::group_t g, input insn_t s);
    slotGroup[i] = g;
    slotKind[i] = s.k;
    slotSrcA[i] = s.a;
    slotSrcB[i] = s.b;
    slotDst[i] = s.d;
    slotLatency[i] = s.lat;
    slotWbLatency[i] = s.wb;
    slotLockCycles[i] = s.lat;
    slotIssueRate[i] = s.rate;
    slotLockMask[i] = s.lock;
    slotNeedMask[i] = s.need;
  endtask
  // new offer, settled before the check
  task automatic offerNew(input logic [1:0] v);
    offerBits = v;
    offerTog = ~offerTog;
    #1;
  endtask
  task automatic waitIssue(output int cnt);
    cnt = 0;
    while (issueOld !== 1'b1 && cnt < 40) begin
      tick;
      cnt++;
    end
  endtask
  // outlasts the slowest latency and lock
  task automatic drain;
    offerNew(2'h0);
    repeat (12) tick;
  endtask
  task automatic pairTry(input pipe_pkg::group_t g0, g1, input logic dep, expY);
    setSlot(0, g0, '{pipe_pkg::KIND_PLAIN, 0, 0, 30, 1, 1, 1, 0, 0});
    setSlot(1, g1, '{pipe_pkg::KIND_PLAIN, dep ? 30 : 0, 0, 31, 1, 1, 1, 0, 0});
    offerNew(2'h3);
    chkBit("issueOld", 1'b1, issueOld);
    chkBit("issueYoung", expY, issueYoung);
    chkBit("holdYoung", ~expY, holdYoung);
    tick;
    drain;
  endtask

  initial begin
    setSlot(0, pipe_pkg::MOVE_TRANSFER_GROUP, rows[0].c);
    setSlot(1, pipe_pkg::MOVE_TRANSFER_GROUP, rows[0].c);
    repeat (2) tick;
    chkBit("execValid", 1'b0, execValid[0]);
    chkBit("iterBusy", 1'b0, iterBusy);
    repeat (2) tick;
    rst = 1'b0;
    foreach (rows[i]) begin
      setSlot(0, grp(rows[i].p.k), rows[i].p);
      offerNew(2'h1);
      waitIssue(n);
      chkInt("producer stall", 0, n);
      tick;
      chkBit("iterBusy", rows[i].p.k == pipe_pkg::KIND_FP_QUOTIENT_ROOT, iterBusy);
      setSlot(0, grp(rows[i].c.k), rows[i].c);
      offerNew(2'h1);
      waitIssue(n);
      chkInt("consumer stall", rows[i].n, n);
      tick;
      drain;
    end
    pairTry(pipe_pkg::ARITH_LOGIC_GROUP, pipe_pkg::JUMP_GROUP, 1'b0, 1'b1);
    pairTry(pipe_pkg::MOVE_TRANSFER_GROUP, pipe_pkg::MOVE_TRANSFER_GROUP, 1'b0, 1'b1);
    pairTry(pipe_pkg::ARITH_LOGIC_GROUP, pipe_pkg::ARITH_LOGIC_GROUP, 1'b0, 1'b0);
    pairTry(pipe_pkg::SERIAL_ONLY_GROUP, pipe_pkg::ARITH_LOGIC_GROUP, 1'b0, 1'b0);
    pairTry(pipe_pkg::ARITH_LOGIC_GROUP, pipe_pkg::LOAD_STORE_GROUP, 1'b1, 1'b0);
    aUse = 2'h1;
    pairTry(pipe_pkg::ARITH_LOGIC_GROUP, pipe_pkg::LOAD_STORE_GROUP, 1'b1, 1'b1);
    setSlot(0, pipe_pkg::MOVE_TRANSFER_GROUP, rows[11].c);
    offerNew(2'h1);
    tick;
    itlbMiss = 1'b1;
    setSlot(0, pipe_pkg::LOAD_STORE_GROUP, rows[4].c);
    offerNew(2'h1);
    chkBit("issueOld", 1'b0, issueOld);
    chkBit("fetchStall", 1'b1, fetchStall);
    tick;
    chkBit("accessValid", 1'b1, accessValid[0]);
    itlbMiss = 1'b0;
    extInstrFetch = 1'b1;
    tick;
    chkBit("writebackValid", 1'b1, writebackValid[0]);
    extInstrFetch = 1'b0;
    tick;
    extDataWait = 1'b1;
    #1;
    chkBit("pipeFrozen", 1'b1, pipeFrozen);
    tick;
    extDataWait = 1'b0;
    ctrlRegWait = 1'b1;
    tick;
    chkBit("execValid", 1'b1, execValid[0]);
    chkBit("accessValid", 1'b0, accessValid[0]);
    ctrlRegWait = 1'b0;
    tick;
    chkBit("accessIsMemory", 1'b1, accessIsMemory[0]);
    drain;
    summarize;
  end

  initial begin
    repeat (5000) @(posedge clock);
    nErrors++;
    summarize;
  end
endmodule
`default_nettype wire

// ---- verification/fetch_feed_model.sv ----
/*
  Fetch-side model: offers decoded slots and holds each until it issues.
  Assumes the bench sets slot fields and toggles offerTog for a new offer.
*/
`timescale 1ns/1ps
`default_nettype none
module fetch_feed_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] offer,
  input  wire logic       offerTog,
  input  wire logic       issueOld,
  input  wire logic       issueYoung,
  output logic [1:0]      slotValid
);
  logic            seenTog_r;
  logic [1:0]      done_r;
  wire logic       fresh = offerTog != seenTog_r;
  wire logic [1:0] doneNow = fresh ? 2'h0 : done_r;
  // held until its own issue edge, never withdrawn early
  assign slotValid = offer & ~doneNow;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seenTog_r <= 1'b0;
      done_r <= 2'h0;
    end else begin
      seenTog_r <= offerTog;
      done_r <= doneNow | {issueYoung, issueOld};
    end
  end
endmodule
`default_nettype wire

// ---- verification/interlock_monitor.sv ----
/*
  Concurrent checks on the interlock's issue, freeze and stage outputs.
  Assumes it is bound onto dual_issue_pipeline_interlock, one core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module interlock_monitor (
  input wire logic                          clock,
  input wire logic                          rst,
  input wire logic [1:0]                    slotValid,
  input wire pipe_pkg::group_t              slotGroup      [0:1],
  input wire pipe_pkg::kind_t               slotKind       [0:1],
  input wire logic [pipe_pkg::LSTART_W-1:0] slotLockStart  [0:1],
  input wire logic [pipe_pkg::LAT_W-1:0]    slotLockCycles [0:1],
  input wire logic                          itlbMiss,
  input wire logic                          extInstrFetch,
  input wire logic                          extDataWait,
  input wire logic                          ctrlRegWait,
  input wire logic                          issueOld,
  input wire logic                          issueYoung,
  input wire logic                          holdYoung,
  input wire logic                          fetchStall,
  input wire logic                          pipeFrozen,
  input wire logic [1:0]                    execValid,
  input wire logic [1:0]                    accessValid,
  input wire logic [1:0]                    writebackValid,
  input wire logic                          iterBusy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_FETCH_NO_ISSUE: assert property ((itlbMiss || extInstrFetch) |-> fetchStall && !issueOld)
    else $error("issue during fetch penalty");
  AST_FREEZE_NO_ISSUE: assert property ((extDataWait || ctrlRegWait) |-> pipeFrozen && !issueOld && !issueYoung)
    else $error("issue during data freeze");
  AST_FREEZE_HOLDS: assert property (pipeFrozen |=> $stable(execValid) && $stable(accessValid) && $stable(writebackValid) && $stable(iterBusy))
    else $error("stages moved while frozen");
  AST_YOUNG_WITH_OLD: assert property (issueYoung |-> issueOld && slotValid[1])
    else $error("younger issued without older");
  AST_HOLD_ALONE: assert property (holdYoung |-> issueOld && !issueYoung)
    else $error("hold without lone older issue");
  AST_SERIAL_ALONE: assert property (issueYoung |-> slotGroup[0] != pipe_pkg::SERIAL_ONLY_GROUP && slotGroup[1] != pipe_pkg::SERIAL_ONLY_GROUP)
    else $error("serial group paired");
  AST_OLD_VALID: assert property (issueOld |-> slotValid[0] && !fetchStall && !pipeFrozen)
    else $error("issue of empty or stalled slot");
  AST_EXEC_AFTER_ISSUE: assert property (issueOld |=> execValid[0] && execValid[1] == $past(issueYoung))
    else $error("execute stage not filled by issue");
  AST_EXEC_ONLY_ISSUE: assert property (!issueOld && !pipeFrozen |=> execValid == 2'h0)
    else $error("execute stage filled without issue");
  AST_STAGE_CHAIN: assert property (!pipeFrozen |=> accessValid == $past(execValid) && writebackValid == $past(accessValid))
    else $error("stage occupancy did not advance");
  AST_ITER_START: assert property (issueOld && slotKind[0] == pipe_pkg::KIND_FP_QUOTIENT_ROOT && slotLockStart[0] == 3'h0 && slotLockCycles[0] != 5'h00 |=> iterBusy)
    else $error("iterative stage not busy after quotient");

  cover property (issueYoung);
  cover property (holdYoung);
  cover property (pipeFrozen && execValid[0]);
  cover property (iterBusy);
endmodule

bind dual_issue_pipeline_interlock interlock_monitor u_mon (
  .clock, .rst, .slotValid, .slotGroup, .slotKind, .slotLockStart, .slotLockCycles,
  .itlbMiss, .extInstrFetch, .extDataWait, .ctrlRegWait, .issueOld, .issueYoung,
  .holdYoung, .fetchStall, .pipeFrozen, .execValid, .accessValid, .writebackValid, .iterBusy
);
`default_nettype wire
